// ==== verilog/pir_regs.svh ====
// Summary of operation
// - each source forwards onto at most one core input; codes seven and up reach none
// - software rewrites assignments; defaults load at reset
// - core events ranked, zero is highest priority
// - core id zero means level seven, upward
// - ids zero to thirteen default to core zero
// - ids fourteen, fifteen default to core one
// - ids 16-19 core two, 20-25 core three
// - ids 26 to 31 default to core four
// - 32-41 core five, 42-46 core six
// - 47-50 core zero, 51-55 core three
// - eight fields per register; low/high bit sets
// - ids 10, 11, 51 reserved, no source
// - set mask bit forwards, clear bit blocks
// - status bit follows its live request
// - enabled wakeup bit requests core wakeup
// - edge seen in two cycles, pending after three
`ifndef PIR_REGS_SVH
`define PIR_REGS_SVH

`define PIR_NUM_SOURCES   56
`define PIR_LOW_SOURCES   32
`define PIR_HIGH_SOURCES  24
`define PIR_NUM_CORE_IN   7
`define PIR_FIELD_W       4
`define PIR_FIELDS_PER_REG 8
`define PIR_NUM_ASSIGN    7
`define PIR_ASSIGN_IDX_W  3
`define PIR_REG_W         32

// reserved source positions
`define PIR_RSVD_A        10
`define PIR_RSVD_B        11
`define PIR_RSVD_C        51

// reset values of the seven assignment registers
`define PIR_ASSIGN0_RST   32'h00000000
`define PIR_ASSIGN1_RST   32'h11000000
`define PIR_ASSIGN2_RST   32'h33332222
`define PIR_ASSIGN3_RST   32'h44444433
`define PIR_ASSIGN4_RST   32'h55555555
`define PIR_ASSIGN5_RST   32'h06666655
`define PIR_ASSIGN6_RST   32'h33333000

// core event levels
`define PIR_NUM_LEVELS    16
`define PIR_LEVEL_W       4
`define PIR_LVL_EMULATION 0
`define PIR_LVL_RESET     1
`define PIR_LVL_NMI       2
`define PIR_LVL_EXCEPTION 3
`define PIR_LVL_RESERVED  4
`define PIR_LVL_HW_ERROR  5
`define PIR_LVL_TIMER     6
`define PIR_GENERAL_LOW   7
`define PIR_NUM_GENERAL   9

`endif

// ==== verilog/pir_pkg.sv ====
package pir_pkg;
    typedef logic [3:0]  pir_field_t;
    typedef logic [3:0]  pir_level_t;
    typedef logic [31:0] pir_word_t;
endpackage

// ==== verilog/pir_event_rank.sv ====
`timescale 1ns/1ps
`include "pir_regs.svh"

module pir_event_rank #(
    parameter int NUM_LEVELS = `PIR_NUM_LEVELS
) (
    input  wire logic                    clock,
    input  wire logic                    rst,
    input  wire logic [NUM_LEVELS-1:0]   event_in,
    input  wire logic [NUM_LEVELS-1:0]   event_ack,
    output pir_pkg::pir_level_t          top_level,
    output logic                         top_valid,
    output logic [NUM_LEVELS-1:0]        event_pending
);
    logic [NUM_LEVELS-1:0] sample;
    logic [NUM_LEVELS-1:0] sample_prev;
    logic [NUM_LEVELS-1:0] latched;
    logic [NUM_LEVELS-1:0] rise;
    logic [NUM_LEVELS-1:0] next_latched;
    logic [NUM_LEVELS-1:0] next_pending;
    logic [NUM_LEVELS-1:0] winner;
    pir_pkg::pir_level_t   next_top;

    // edge detected one edge after the input rises, latched on the second
    assign rise = sample & ~sample_prev;
    // a new edge wins over the clear from acceptance
    assign next_latched = (latched & ~event_pending) | rise;

    // lowest index wins: zero is the highest priority
    assign winner = latched & ~(latched - NUM_LEVELS'(1));
    assign next_pending = (event_pending & ~event_ack) | winner;

    always_comb begin
        next_top = pir_pkg::pir_level_t'(0);
        for (int i = NUM_LEVELS - 1; i >= 0; i--) begin
            if (next_pending[i]) begin
                next_top = pir_pkg::pir_level_t'(i);
            end
        end
    end

    // sampling, latch and pending stages
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sample        <= '0;
            sample_prev   <= '0;
            latched       <= '0;
            event_pending <= '0;
            top_level     <= '0;
            top_valid     <= 1'b0;
        end else begin
            sample        <= event_in;
            sample_prev   <= sample;
            latched       <= next_latched;
            event_pending <= next_pending;
            top_level     <= next_top;
            top_valid     <= |next_pending;
        end
    end
endmodule

// ==== verilog/pir_router.sv ====
`timescale 1ns/1ps
`include "pir_regs.svh"

module pir_router #(
    parameter int NUM_SOURCES = `PIR_NUM_SOURCES,
    parameter int NUM_CORE_IN = `PIR_NUM_CORE_IN
) (
    input  wire logic                          clock,
    input  wire logic                          rst,
    // peripheral requests, same clock domain
    input  wire logic [NUM_SOURCES-1:0]        periph_request,
    // mask and wakeup enables, low and high sets
    input  wire logic [`PIR_LOW_SOURCES-1:0]   source_mask_set_low,
    input  wire logic [`PIR_HIGH_SOURCES-1:0]  source_mask_set_high,
    input  wire logic [`PIR_LOW_SOURCES-1:0]   source_wakeup_set_low,
    input  wire logic [`PIR_HIGH_SOURCES-1:0]  source_wakeup_set_high,
    // assignment register write and read
    input  wire logic                          assign_wr_en,
    input  wire logic [`PIR_ASSIGN_IDX_W-1:0]  assign_wr_index,
    input  wire logic [`PIR_REG_W-1:0]         assign_wr_data,
    input  wire logic [`PIR_ASSIGN_IDX_W-1:0]  assign_rd_index,
    output logic [`PIR_REG_W-1:0]              assign_rd_data,
    // status sets
    output logic [`PIR_LOW_SOURCES-1:0]        source_status_set_low,
    output logic [`PIR_HIGH_SOURCES-1:0]       source_status_set_high,
    // core side
    output logic [NUM_CORE_IN-1:0]             core_request,
    output logic                               wakeup_request,
    input  wire logic [`PIR_GENERAL_LOW-1:0]   core_fixed_event,
    input  wire logic [1:0]                    core_soft_event,
    input  wire logic [`PIR_NUM_LEVELS-1:0]    core_event_ack,
    output pir_pkg::pir_level_t                core_top_level,
    output logic                               core_top_valid,
    output logic [`PIR_NUM_LEVELS-1:0]         core_event_pending
);
    localparam int FW = `PIR_FIELD_W;
    localparam int FPR = `PIR_FIELDS_PER_REG;
    localparam int NREG = `PIR_NUM_ASSIGN;

    // default mapping, loaded by reset
    localparam pir_pkg::pir_word_t ASSIGN_RST [NREG] = '{
        `PIR_ASSIGN0_RST,
        `PIR_ASSIGN1_RST,
        `PIR_ASSIGN2_RST,
        `PIR_ASSIGN3_RST,
        `PIR_ASSIGN4_RST,
        `PIR_ASSIGN5_RST,
        `PIR_ASSIGN6_RST
    };

    // assignment storage, one word per register
    pir_pkg::pir_word_t            interrupt_assignment_regs [NREG];

    logic [NUM_SOURCES-1:0]        reserved_pos;
    logic [NUM_SOURCES-1:0]        live_request;
    logic [NUM_SOURCES-1:0]        mask_all;
    logic [NUM_SOURCES-1:0]        wake_all;
    logic [NUM_SOURCES-1:0]        unmasked;
    logic [NUM_CORE_IN-1:0]        level_hit [NUM_SOURCES];
    logic [NUM_SOURCES-1:0]        per_level [NUM_CORE_IN];
    logic [NUM_CORE_IN-1:0]        next_core_request;
    logic                          next_wakeup;
    logic [`PIR_REG_W-1:0]         next_rd_data;
    logic [`PIR_NUM_LEVELS-1:0]    rank_in;

    // reserved positions carry no source
    always_comb begin
        reserved_pos = '0;
        reserved_pos[`PIR_RSVD_A] = 1'b1;
        reserved_pos[`PIR_RSVD_B] = 1'b1;
        reserved_pos[`PIR_RSVD_C] = 1'b1;
    end
    assign live_request = periph_request & ~reserved_pos;

    // low set holds ids 0-31, high set ids 32-55
    assign mask_all = {source_mask_set_high, source_mask_set_low};
    assign wake_all = {source_wakeup_set_high, source_wakeup_set_low};
    assign unmasked = live_request & mask_all;

    // per source: decode its field into a one-hot target
    genvar s, k;
    generate
        for (s = 0; s < NUM_SOURCES; s++) begin : g_src
            pir_pkg::pir_field_t field;
            logic                code_ok;
            // eight fields per register, field s%8 of register s/8
            assign field = interrupt_assignment_regs[s / FPR][(s % FPR) * FW +: FW];
            // codes seven and up reach no core input
            assign code_ok = (int'(field) < NUM_CORE_IN);
            for (k = 0; k < NUM_CORE_IN; k++) begin : g_lvl
                // code k drives core input k (level seven plus k)
                assign level_hit[s][k] = unmasked[s] && code_ok &&
                                         (field == pir_pkg::pir_field_t'(k));
                assign per_level[k][s] = level_hit[s][k];
            end
        end
    endgenerate

    // codes above six match no core input
    generate
        for (k = 0; k < NUM_CORE_IN; k++) begin : g_or
            assign next_core_request[k] = |per_level[k];
        end
    endgenerate

    assign next_wakeup = |(live_request & wake_all);
    assign next_rd_data = (int'(assign_rd_index) < NREG)
                        ? interrupt_assignment_regs[assign_rd_index] : '0;

    // assignment registers, defaults at reset
    generate
        for (s = 0; s < NREG; s++) begin : g_reg
            logic wr_hit;
            // strobe decoded per register, index seven hits none
            assign wr_hit = assign_wr_en &&
                            (assign_wr_index == `PIR_ASSIGN_IDX_W'(s));
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    interrupt_assignment_regs[s] <= ASSIGN_RST[s];
                end else if (wr_hit) begin
                    interrupt_assignment_regs[s] <= assign_wr_data;
                end
            end
        end
    endgenerate

    // core requests, one cycle after the request level
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            core_request <= '0;
        end else begin
            core_request <= next_core_request;
        end
    end

    // wakeup request, mask does not gate it
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wakeup_request <= 1'b0;
        end else begin
            wakeup_request <= next_wakeup;
        end
    end

    // status follows live requests, reserved ids read zero
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            source_status_set_low  <= '0;
            source_status_set_high <= '0;
        end else begin
            source_status_set_low  <= live_request[`PIR_LOW_SOURCES-1:0];
            source_status_set_high <= live_request[NUM_SOURCES-1:`PIR_LOW_SOURCES];
        end
    end

    // readback of the selected assignment word
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            assign_rd_data <= '0;
        end else begin
            assign_rd_data <= next_rd_data;
        end
    end

    // core event inputs in rank order
    assign rank_in = {core_soft_event, core_request, core_fixed_event};

    pir_event_rank #(
        .NUM_LEVELS (`PIR_NUM_LEVELS)
    ) u_rank (
        .clock         (clock),
        .rst           (rst),
        .event_in      (rank_in),
        .event_ack     (core_event_ack),
        .top_level     (core_top_level),
        .top_valid     (core_top_valid),
        .event_pending (core_event_pending)
    );
endmodule

// ==== verilog/pir_defaults_note.sv ====
`timescale 1ns/1ps

// ==== verif/pir_router_sva.sv ====
`timescale 1ns/1ps
module pir_router_sva #(
    parameter int NUM_SOURCES = 56,
    parameter int NUM_CORE_IN = 7
) (
    input wire logic                   clock,
    input wire logic                   rst,
    input wire logic [NUM_SOURCES-1:0] periph_request,
    input wire logic [31:0]            source_mask_set_low,
    input wire logic [23:0]            source_mask_set_high,
    input wire logic [31:0]            source_wakeup_set_low,
    input wire logic [23:0]            source_wakeup_set_high,
    input wire logic [31:0]            source_status_set_low,
    input wire logic [23:0]            source_status_set_high,
    input wire logic [NUM_CORE_IN-1:0] core_request,
    input wire logic                   wakeup_request,
    input wire logic [6:0]             core_fixed_event,
    input wire pir_pkg::pir_level_t    core_top_level,
    input wire logic                   core_top_valid,
    input wire logic [15:0]            core_event_pending
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // live and forwarded requests, reserved ids dropped
    wire logic [55:0] live = periph_request & ~56'h08000000000c00;
    wire logic [55:0] fwd  = live & {source_mask_set_high, source_mask_set_low};
    wire logic [55:0] wen  = {source_wakeup_set_high, source_wakeup_set_low};
    sequence s_rise; $rose(core_request[0]); endsequence
    sequence s_pend; ##[1:20] core_event_pending[7]; endsequence
    property p_status; !$past(rst) |->
        {source_status_set_high, source_status_set_low} == $past(live); endproperty
    a_status: assert property (p_status) else $error("status mismatch");
    property p_wake; !$past(rst) |-> wakeup_request == $past(|(live & wen)); endproperty
    a_wake: assert property (p_wake) else $error("wakeup mismatch");
    property p_block; !$past(rst) && $past(fwd) == '0 |-> core_request == '0; endproperty
    a_block: assert property (p_block) else $error("masked leak");
    property p_one; !$past(rst) && $past($onehot(fwd)) |-> $onehot0(core_request); endproperty
    a_one: assert property (p_one) else $error("source on two inputs");
    property p_edge; s_rise |-> s_pend; endproperty
    a_edge: assert property (p_edge) else $error("edge not pending");
    property p_fixed; $rose(core_fixed_event[1]) |-> ##[1:20] core_event_pending[1]; endproperty
    a_fixed: assert property (p_fixed) else $error("fixed event lost");
    property p_valid; core_top_valid == (|core_event_pending); endproperty
    a_valid: assert property (p_valid) else $error("valid mismatch");
    property p_top; core_top_valid |-> core_event_pending[core_top_level] &&
        (core_event_pending & ((16'h1 << core_top_level) - 16'h1)) == 16'h0; endproperty
    a_top: assert property (p_top) else $error("top level wrong");
endmodule
bind pir_router pir_router_sva #(.NUM_SOURCES(NUM_SOURCES), .NUM_CORE_IN(NUM_CORE_IN))
    u_pir_router_sva (.clock, .rst, .periph_request, .source_mask_set_low,
    .source_mask_set_high, .source_wakeup_set_low, .source_wakeup_set_high,
    .source_status_set_low, .source_status_set_high, .core_request, .wakeup_request,
    .core_fixed_event, .core_top_level, .core_top_valid, .core_event_pending);

// ==== verif/pir_core_model.sv ====
`timescale 1ns/1ps
module pir_core_model #(
    parameter bit SLOW = 1'b1
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [15:0] event_pending,
    output logic [6:0]       fixed_event,
    output logic [1:0]       soft_event,
    output logic [15:0]      event_ack
);
    logic [12:0] cnt;
    // fixed and soft levels from a counter, pending acked fast or late
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt <= '0;
            fixed_event <= '0;
            soft_event <= '0;
            event_ack <= '0;
        end else begin
            cnt <= cnt + 13'h1;
            fixed_event <= cnt[12:6];
            soft_event <= cnt[5:4];
            event_ack <= SLOW ? event_pending & {16{&cnt[2:0]}} : event_pending;
        end
    end
endmodule

// ==== verif/peripheral_interrupt_router_tb.sv ====
`timescale 1ns/1ps
module peripheral_interrupt_router_tb;
    localparam logic [55:0] RSV = 56'h08000000000c00;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [55:0] req = '0;
    logic [55:0] msk = '0;
    logic [55:0] wak = '0;
    logic        we = 1'b0;
    logic [2:0]  wi = '0;
    logic [2:0]  ri = '0;
    logic [31:0] wd = '0;
    logic [31:0] rdd;
    logic [55:0] sts;
    logic [6:0]  creq;
    logic        wkr;
    logic [6:0]  fx;
    logic [1:0]  sf;
    logic [15:0] ack;
    logic [15:0] pend;
    logic [31:0] areg [8];
    logic [95:0] exp_q [$];
    logic [95:0] e;
    int          n_fail = 0;
    int          cmp_count = 0;
    integer      seed = 32'ha772;
    event        ev_chk;
    pir_router u_pir_router (.clock(clock), .rst(rst), .periph_request(req),
        .source_mask_set_low(msk[31:0]), .source_mask_set_high(msk[55:32]),
        .source_wakeup_set_low(wak[31:0]), .source_wakeup_set_high(wak[55:32]),
        .assign_wr_en(we), .assign_wr_index(wi), .assign_wr_data(wd),
        .assign_rd_index(ri), .assign_rd_data(rdd), .source_status_set_low(sts[31:0]),
        .source_status_set_high(sts[55:32]), .core_request(creq), .wakeup_request(wkr),
        .core_fixed_event(fx), .core_soft_event(sf), .core_event_ack(ack),
        .core_top_level(), .core_top_valid(), .core_event_pending(pend));
    pir_core_model u_pir_core_model (.clock(clock), .rst(rst), .event_pending(pend),
        .fixed_event(fx), .soft_event(sf), .event_ack(ack));
    // clock and watchdog
    initial forever #2 clock = ~clock;
    initial begin
        #20000;
        n_fail++;
        tally_and_finish();
    end
    function automatic logic [3:0] dflt(input int id);
        if (id < 14 || (id > 46 && id < 51)) return 4'h0;
        if (id < 16) return 4'h1;
        if (id < 20) return 4'h2;
        if (id < 26 || id > 50) return 4'h3;
        if (id < 32) return 4'h4;
        return (id < 42) ? 4'h5 : 4'h6;
    endfunction
    function automatic logic [6:0] route(input logic [55:0] r);
        logic [3:0] c;
        route = '0;
        for (int i = 0; i < 56; i++) begin
            c = areg[i/8][4*(i%8)+:4];
            if (r[i] && c < 4'h7) route[c] = 1'b1;
        end
    endfunction
    task automatic do_reset;
        @(negedge clock);
        rst = 1'b1;
        for (int k = 0; k < 64; k++) areg[k/8][4*(k%8)+:4] = (k < 56) ? dflt(k) : 4'h0;
        repeat (2) @(negedge clock);
        rst = 1'b0;
    endtask
    task automatic wr(input logic [2:0] i, input logic [31:0] d);
        @(negedge clock);
        we = 1'b1;
        wi = i;
        wd = d;
        @(negedge clock);
        we = 1'b0;
        if (i != 3'h7) areg[i] = d;
    endtask
    task automatic step(input logic [55:0] r, m, w, input logic [2:0] i);
        logic [55:0] lv;
        @(negedge clock);
        req = r;
        msk = m;
        wak = w;
        ri = i;
        lv = r & ~RSV;
        exp_q.push_back({areg[i], route(lv & m), |(lv & w), lv});
        @(posedge clock);
        #1 -> ev_chk;
    endtask
    // compare oldest note with the outputs
    initial forever begin
        @(ev_chk);
        e = exp_q.pop_front();
        cmp_count++;
        if ({rdd, creq, wkr, sts} !== e) begin
            n_fail++;
            $display("[ERR] %0t exp %h got %h", $time, e, {rdd, creq, wkr, sts});
        end
    end
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // defaults, single sources, masks, codes, random, second reset
    initial begin
        do_reset();
        for (int k = 0; k < 8; k++) step('0, '0, '0, 3'(k));
        for (int k = 0; k < 56; k++) step(56'h1 << k, '1, '0, 3'(k/8));
        step('1, '0, '1, 3'h0);
        for (int c = 0; c < 9; c++) begin
            wr(3'h2, {8{4'(c)}});
            step(56'hff0000, '1, '0, 3'h2);
        end
        wr(3'h7, '1);
        step('0, '0, '0, 3'h7);
        for (int n = 0; n < 60; n++) begin
            if (n % 4 == 0) wr(3'($random(seed)), $random(seed));
            step(56'({$random(seed), $random(seed)}), 56'({$random(seed), $random(seed)}),
                56'({$random(seed), $random(seed)}), 3'($random(seed)));
        end
        do_reset();
        for (int k = 0; k < 8; k++) step('0, '0, '0, 3'(k));
        @(negedge clock);
        tally_and_finish();
    end
endmodule
